// >>> verilog/dual_mode_select.sv
// module: dual control mode selection, command routing and limits with an AXI4-Lite register file
`timescale 1ns/1ps
module dual_mode_select #(
  parameter int POS_ENTRIES = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [mode_select_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [mode_select_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire mode_select_pkg::pins_s pins,
  input wire logic [15:0] analog_in,
  input wire logic [31:0] pulse_position,
  output mode_select_pkg::drive_cmd_s drive_cmd
);
  import mode_select_pkg::*;

  if (POS_ENTRIES < 1 || POS_ENTRIES > (1 << POS_SEL_W)) begin : g_check
    $error("POS_ENTRIES must lie between 1 and the reach of the position select inputs");
  end

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [7:0] func;
    logic [14:0] max_vel;
    logic [PRESETS-1:0][15:0] vel_pre;
    logic [PRESETS-1:0][15:0] trq_pre;
    logic [POS_ENTRIES-1:0][31:0] pos_tab;
    pins_s sync1;
    pins_s sync2;
    logic trig_prev;
    logic hold;
    logic [31:0] pos_latched;
    drive_cmd_s cmd;
  } state_s;

  state_s state_reg;
  state_s state_next;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] abs_sat(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (v[15]) begin
      r = (v == 16'h8000) ? 16'h7fff : 16'(-v);
    end
    return r;
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [14:0] m);
    logic signed [15:0] sv;
    logic signed [15:0] sm;
    logic [15:0] r;
    sv = signed'(v);
    sm = signed'({1'b0, m});
    r = v;
    if (sv > sm) begin
      r = {1'b0, m};
    end else if (sv < -sm) begin
      r = 16'(-sm);
    end
    return r;
  endfunction

  // returns {ok, data} for a read of the given byte address
  function automatic logic [32:0] read_word(input state_s s, input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    logic [ADDR_W-1:0] rel;
    r = {1'b0, 32'h0000_0000};
    rel = 8'h00;
    if (a == CTRL_OFS) begin
      r = {1'b1, s.ctrl};
    end else if (a == FUNC_OFS) begin
      r = {1'b1, 24'h00_0000, s.func};
    end else if (a == MAX_VEL_OFS) begin
      r = {1'b1, 17'h0_0000, s.max_vel};
    end else if (a == STATUS_OFS) begin
      r = {1'b1, 13'h0000, s.cmd.trq_limit_on, s.cmd.vel_limit_on, s.cmd.motion_hold, s.cmd.mode, 14'h0000};
      r[15:0] = s.pos_latched[15:0];
    end else if (a >= VEL_PRESET_OFS && a < VEL_PRESET_OFS + 8'(4 * PRESETS)) begin
      rel = a - VEL_PRESET_OFS;
      r = {1'b1, 16'h0000, s.vel_pre[rel[3:2]]};
    end else if (a >= TRQ_PRESET_OFS && a < TRQ_PRESET_OFS + 8'(4 * PRESETS)) begin
      rel = a - TRQ_PRESET_OFS;
      r = {1'b1, 16'h0000, s.trq_pre[rel[3:2]]};
    end else if (a >= POS_TABLE_OFS && a < POS_TABLE_OFS + 8'(4 * POS_ENTRIES)) begin
      rel = a - POS_TABLE_OFS;
      r = {1'b1, s.pos_tab[rel[7:2]]};
    end
    // a byte offset inside a word is refused
    if (a[1:0] != 2'h0) begin
      r = {1'b0, 32'h0000_0000};
    end
    return r;
  endfunction

  logic [32:0] rd;
  logic [ADDR_W-1:0] wrel;
  logic [31:0] wmerged;
  logic wr_ok;
  logic [MODE_W-1:0] cm;
  logic dual;
  mode_e mode_lo;
  mode_e mode_hi;
  logic [7:0] req_fn;
  mode_e mode_new;
  logic trig_rise;
  logic [15:0] vel_raw;
  logic [15:0] trq_raw;
  logic [15:0] trq_lim_src;
  logic [1:0] tsel;
  logic [31:0] table_entry;

  always_comb begin
    state_next = state_reg;
    // ready drops while a response is outstanding or the enable is low
    awready = ce && !state_reg.aw_held && !state_reg.bvalid;
    wready = ce && !state_reg.w_held && !state_reg.bvalid;
    arready = ce && !state_reg.rvalid;
    rd = read_word(state_reg, araddr);
    wrel = 8'h00;
    wmerged = 32'h0000_0000;
    wr_ok = 1'b0;
    cm = state_reg.ctrl[MODE_LSB +: MODE_W];
    dual = 1'b1;
    mode_lo = MODE_VEL;
    mode_hi = MODE_VEL;
    req_fn = FN_POS_VEL;
    mode_new = MODE_VEL;
    trig_rise = 1'b0;
    vel_raw = 16'h0000;
    trq_raw = 16'h0000;
    trq_lim_src = 16'h0000;
    tsel = {state_reg.sync2.torque_select_bit_high, state_reg.sync2.torque_select_bit_low};
    table_entry = 32'h0000_0000;
    if (ce) begin
      // write path: address and data may arrive in either order
      if (awvalid && awready) begin
        state_next.aw_held = 1'b1;
        state_next.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
        state_next.w_held = 1'b1;
        state_next.w_data = wdata;
        state_next.w_strb = wstrb;
      end
      if (state_reg.bvalid && bready) begin
        state_next.bvalid = 1'b0;
      end
      if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
        state_next.aw_held = 1'b0;
        state_next.w_held = 1'b0;
        state_next.bvalid = 1'b1;
        wr_ok = read_word(state_reg, state_reg.aw_addr) >> 32 != 33'h0;
        state_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_ok) begin
          if (state_reg.aw_addr == CTRL_OFS) begin
            state_next.ctrl = merge(state_reg.ctrl, state_reg.w_data, state_reg.w_strb);
          end else if (state_reg.aw_addr == FUNC_OFS) begin
            wmerged = merge({24'h00_0000, state_reg.func}, state_reg.w_data, state_reg.w_strb);
            state_next.func = wmerged[7:0];
          end else if (state_reg.aw_addr == MAX_VEL_OFS) begin
            wmerged = merge({17'h0_0000, state_reg.max_vel}, state_reg.w_data, state_reg.w_strb);
            state_next.max_vel = wmerged[14:0];
          end else if (state_reg.aw_addr >= POS_TABLE_OFS) begin
            wrel = state_reg.aw_addr - POS_TABLE_OFS;
            state_next.pos_tab[wrel[7:2]] =
              merge(state_reg.pos_tab[wrel[7:2]], state_reg.w_data, state_reg.w_strb);
          end else if (state_reg.aw_addr >= TRQ_PRESET_OFS) begin
            wrel = state_reg.aw_addr - TRQ_PRESET_OFS;
            wmerged = merge({16'h0000, state_reg.trq_pre[wrel[3:2]]}, state_reg.w_data, state_reg.w_strb);
            state_next.trq_pre[wrel[3:2]] = wmerged[15:0];
          end else if (state_reg.aw_addr >= VEL_PRESET_OFS) begin
            wrel = state_reg.aw_addr - VEL_PRESET_OFS;
            wmerged = merge({16'h0000, state_reg.vel_pre[wrel[3:2]]}, state_reg.w_data, state_reg.w_strb);
            state_next.vel_pre[wrel[3:2]] = wmerged[15:0];
          end
        end
      end
      // read path
      if (state_reg.rvalid && rready) begin
        state_next.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
        state_next.rvalid = 1'b1;
        state_next.rdata = rd[31:0];
        state_next.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      end

      // pin inputs pass two flops; only the second one is read
      state_next.sync1 = pins;
      state_next.sync2 = state_reg.sync1;
      state_next.trig_prev = state_reg.sync2.trigger;
      trig_rise = state_reg.sync2.trigger && !state_reg.trig_prev;

      // pairing table; mode changes are taken whatever the servo state
      unique case (cm)
        CM_PT_V: begin
          mode_lo = MODE_VEL;
          mode_hi = MODE_PT;
          req_fn = FN_POS_VEL;
        end
        CM_PT_T: begin
          mode_lo = MODE_TRQ;
          mode_hi = MODE_PT;
          req_fn = FN_POS_TRQ;
        end
        CM_PR_V: begin
          mode_lo = MODE_VEL;
          mode_hi = MODE_PR;
          req_fn = FN_POS_VEL;
        end
        CM_PR_T: begin
          mode_lo = MODE_TRQ;
          mode_hi = MODE_PR;
          req_fn = FN_POS_TRQ;
        end
        CM_V_T: begin
          mode_lo = MODE_VEL;
          mode_hi = MODE_TRQ;
          req_fn = FN_VEL_TRQ;
        end
        default: begin
          dual = 1'b0;
        end
      endcase
      // the select level is followed every cycle, no servo-off needed
      if (dual && state_reg.func == req_fn && state_reg.sync2.mode_sel) begin
        mode_new = mode_hi;
      end else begin
        mode_new = mode_lo;
      end
      state_next.cmd.mode = mode_new;

      // position source
      // selections past the populated table read as zero
      table_entry = state_reg.pos_tab[state_reg.sync2.pos_sel];
      if (32'(state_reg.sync2.pos_sel) >= 32'(POS_ENTRIES)) begin
        table_entry = 32'h0000_0000;
      end
      if (mode_new == MODE_PR) begin
        // entry into table mode keeps the hold set until a trigger rises
        if (trig_rise) begin
          state_next.pos_latched = table_entry;
          state_next.hold = 1'b0;
        end
      end else begin
        state_next.hold = 1'b1;
      end
      if (mode_new == MODE_PT) begin
        state_next.cmd.pos_cmd = pulse_position;
        state_next.cmd.motion_hold = 1'b0;
      end else if (mode_new == MODE_PR) begin
        state_next.cmd.pos_cmd = state_next.pos_latched;
        state_next.cmd.motion_hold = state_next.hold;
      end else begin
        state_next.cmd.pos_cmd = state_reg.cmd.pos_cmd;
        state_next.cmd.motion_hold = 1'b0;
      end

      // velocity command and limit
      // selector code 0 picks the analog input, codes 1 to 3 the presets
      vel_raw = (state_reg.sync2.vel_sel == 2'h0) ? analog_in :
        state_reg.vel_pre[state_reg.sync2.vel_sel - 2'h1];
      state_next.cmd.vel_cmd = (mode_new == MODE_VEL) ? clamp(vel_raw, state_reg.max_vel) : 16'h0000;
      state_next.cmd.vel_limit_on = (mode_new == MODE_TRQ) &&
        (state_reg.ctrl[VLIM_DIGIT_LSB +: 4] == DIGIT_ON);
      state_next.cmd.vel_limit = state_next.cmd.vel_limit_on ?
        clamp(abs_sat(vel_raw), state_reg.max_vel) : {1'b0, state_reg.max_vel};

      // torque command and limit
      if (tsel == 2'h0) begin
        trq_raw = state_reg.ctrl[ZERO_TRQ_BIT] ? 16'h0000 : analog_in;
        trq_lim_src = analog_in;
      end else begin
        trq_raw = state_reg.trq_pre[tsel - 2'h1];
        trq_lim_src = trq_raw;
      end
      state_next.cmd.trq_cmd = (mode_new == MODE_TRQ) ? trq_raw : 16'h0000;
      state_next.cmd.trq_limit_on = (mode_new != MODE_TRQ) &&
        (state_reg.ctrl[TLIM_DIGIT_LSB +: 4] == DIGIT_ON);
      state_next.cmd.trq_limit = state_next.cmd.trq_limit_on ? abs_sat(trq_lim_src) : TRQ_NO_LIMIT;
    end
  end

  // reset acts whatever the clock enable says
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.ctrl <= CTRL_RST;
      state_reg.func <= FUNC_RST;
      state_reg.max_vel <= MAX_VEL_RST;
      state_reg.hold <= 1'b1;
      state_reg.cmd.vel_limit <= {1'b0, MAX_VEL_RST};
      state_reg.cmd.trq_limit <= TRQ_NO_LIMIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // registered outputs come straight from the state
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign rvalid = state_reg.rvalid;
  assign rdata = state_reg.rdata;
  assign rresp = state_reg.rresp;
  assign drive_cmd = state_reg.cmd;
endmodule // dual_mode_select

// >>> pkg/mode_select_pkg.sv
// package: register map, field layout, modes and carrier structs of the dual mode selector
package mode_select_pkg;
  localparam int ADDR_W = 8;
  localparam int POS_SEL_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] FUNC_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] MAX_VEL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] VEL_PRESET_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] TRQ_PRESET_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] POS_TABLE_OFS = 8'h40;
  localparam int PRESETS = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 5;
  localparam int ZERO_TRQ_BIT = 5;
  localparam int VLIM_DIGIT_LSB = 8;
  localparam int TLIM_DIGIT_LSB = 12;
  localparam logic [MODE_W-1:0] CM_PT_V = 5'h06;
  localparam logic [MODE_W-1:0] CM_PT_T = 5'h07;
  localparam logic [MODE_W-1:0] CM_PR_V = 5'h08;
  localparam logic [MODE_W-1:0] CM_PR_T = 5'h09;
  localparam logic [MODE_W-1:0] CM_V_T = 5'h0a;
  localparam logic [7:0] FN_POS_VEL = 8'h12;
  localparam logic [7:0] FN_VEL_TRQ = 8'h13;
  localparam logic [7:0] FN_POS_TRQ = 8'h14;
  localparam logic [3:0] DIGIT_ON = 4'h1;
  localparam logic [31:0] CTRL_RST = 32'h0000_000a;
  localparam logic [7:0] FUNC_RST = 8'h00;
  localparam logic [14:0] MAX_VEL_RST = 15'h7fff;
  localparam logic [15:0] TRQ_NO_LIMIT = 16'h7fff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_VEL = 2'h0,
    MODE_TRQ = 2'h1,
    MODE_PR = 2'h3,
    MODE_PT = 2'h2
  } mode_e;

  typedef struct packed {
    logic mode_sel;
    logic trigger;
    logic [1:0] vel_sel;
    logic torque_select_bit_high;
    logic torque_select_bit_low;
    logic [POS_SEL_W-1:0] pos_sel;
  } pins_s;

  typedef struct packed {
    mode_e mode;
    logic [31:0] pos_cmd;
    logic motion_hold;
    logic [15:0] vel_cmd;
    logic [15:0] trq_cmd;
    logic vel_limit_on;
    logic [15:0] vel_limit;
    logic trq_limit_on;
    logic [15:0] trq_limit;
  } drive_cmd_s;
endpackage

// >>> tb/dual_mode_select_asserts.sv
// checker: bus hold and mode routing properties of the selector
`timescale 1ns/1ps
module dual_mode_select_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire mode_select_pkg::pins_s pins,
  input wire logic [31:0] pulse_position,
  input wire mode_select_pkg::drive_cmd_s drive_cmd
);
  import mode_select_pkg::*;
  logic [1:0] md;
  logic signed [15:0] vc;
  logic signed [15:0] vl;
  assign md = drive_cmd.mode;
  assign vc = drive_cmd.vel_cmd;
  assign vl = drive_cmd.vel_limit;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence no_pos;
    md == MODE_VEL || md == MODE_TRQ;
  endsequence
  sequence pt_run;
    md == MODE_PT && ce ##1 md == MODE_PT;
  endsequence
  sequence trig_pr;
    md == MODE_PR && ce && $rose(pins.trigger);
  endsequence
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  pos_frozen_a: assert property (no_pos ##1 no_pos |-> $stable(drive_cmd.pos_cmd))
    else $error("position moved outside position mode");
  pulse_follow_a: assert property (pt_run |-> drive_cmd.pos_cmd == $past(pulse_position))
    else $error("pulse position not followed");
  pr_entry_a: assert property (md == MODE_PR && $past(md) != MODE_PR |-> drive_cmd.motion_hold)
    else $error("table mode entered without hold");
  trig_go_a: assert property (trig_pr |-> ##[2:4] !drive_cmd.motion_hold)
    else $error("trigger did not release the move");
  vel_clamp_a: assert property (md == MODE_VEL |-> vc <= vl && vc >= -vl)
    else $error("velocity beyond limit");
  vlim_mode_a: assert property (drive_cmd.vel_limit_on |-> md == MODE_TRQ)
    else $error("velocity limit outside torque mode");
  tlim_mode_a: assert property (drive_cmd.trq_limit_on |-> md != MODE_TRQ)
    else $error("torque limit in torque mode");
  ce_freeze_a: assert property (!ce |=> $stable(drive_cmd) && $stable(rvalid))
    else $error("state moved while the enable was low");
endmodule // dual_mode_select_asserts
bind dual_mode_select dual_mode_select_asserts chk_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .pins(pins), .pulse_position(pulse_position), .drive_cmd(drive_cmd));

// >>> tb/host_model.sv
// host model: drives select, trigger, analog and pulse inputs of the drive
`timescale 1ns/1ps
module host_model (
  input wire logic aclk,
  output mode_select_pkg::pins_s pins,
  output logic [15:0] analog_in,
  output logic [31:0] pulse_position
);
  import mode_select_pkg::*;
  initial begin
    pins = '0;
    analog_in = 16'h0000;
    pulse_position = 32'h0000_0000;
  end
  task automatic drive(input logic m, input logic [1:0] v, input logic [1:0] t, input logic [15:0] a);
    @(posedge aclk);
    pins.mode_sel <= m;
    pins.vel_sel <= v;
    {pins.torque_select_bit_high, pins.torque_select_bit_low} <= t;
    analog_in <= a;
  endtask
  task automatic fire(input logic [3:0] p);
    @(posedge aclk);
    pins.pos_sel <= p;
    repeat (4) @(posedge aclk);
    pins.trigger <= 1'b1;
    repeat (4) @(posedge aclk);
    pins.trigger <= 1'b0;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge aclk);
      pulse_position <= pulse_position + 32'h1;
    end
  endtask
endmodule // host_model

// >>> tb/dual_mode_select_tb.sv
// testbench: registers, dual mode routing, trigger, commands and limits
`timescale 1ns/1ps
module dual_mode_select_tb;
  import mode_select_pkg::*;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  pins_s pins;
  logic [15:0] analog_in;
  logic [31:0] pulse_position;
  drive_cmd_s drive_cmd;
  int errors, comparisons;
  dual_mode_select dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pins(pins),
    .analog_in(analog_in), .pulse_position(pulse_position), .drive_cmd(drive_cmd));
  host_model host_u (.aclk(aclk), .pins(pins), .analog_in(analog_in), .pulse_position(pulse_position));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic close_out;
    $display("counts: %0d errors, %0d comparisons", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic give_up;
    errors++;
    close_out();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && bvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    if (n == 40) give_up();
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (n == 40) give_up();
    got = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic settle;
    repeat (5) @(posedge aclk);
  endtask
  task automatic mode_is(input logic [1:0] e);
    settle();
    chk("mode", {30'h0, e}, {30'h0, drive_cmd.mode});
  endtask
  task automatic t_regs;
    rd(CTRL_OFS);
    chk("ctrl reset", CTRL_RST, got);
    rd(MAX_VEL_OFS);
    chk("max vel reset", {17'h0, MAX_VEL_RST}, got);
    wr(FUNC_OFS, 32'hffff_ff13, 4'h1);
    rd(FUNC_OFS);
    chk("func byte", 32'h0000_0013, got);
    wr(8'h80, 32'h0000_0001, 4'hf, RESP_SLVERR);
    rd(8'h80, RESP_SLVERR);
    chk("unmapped", 32'h0, got);
    $display("test regs done");
  endtask
  task automatic t_pairs;
    logic [4:0] cm [5] = '{CM_PT_V, CM_PT_T, CM_PR_V, CM_PR_T, CM_V_T};
    logic [7:0] fn [5] = '{FN_POS_VEL, FN_POS_TRQ, FN_POS_VEL, FN_POS_TRQ, FN_VEL_TRQ};
    mode_e lo [5] = '{MODE_VEL, MODE_TRQ, MODE_VEL, MODE_TRQ, MODE_VEL};
    mode_e hi [5] = '{MODE_PT, MODE_PT, MODE_PR, MODE_PR, MODE_TRQ};
    for (int i = 0; i < 5; i++) begin
      wr(CTRL_OFS, {27'h0, cm[i]});
      wr(FUNC_OFS, {24'h0, fn[i]});
      host_u.drive(1'b1, 2'h0, 2'h0, 16'h0000);
      mode_is(hi[i]);
      host_u.drive(1'b0, 2'h0, 2'h0, 16'h0000);
      mode_is(lo[i]);
      wr(FUNC_OFS, 32'h0000_0010);
      host_u.drive(1'b1, 2'h0, 2'h0, 16'h0000);
      mode_is(lo[i]);
      host_u.drive(1'b0, 2'h0, 2'h0, 16'h0000);
    end
    $display("test pairs done");
  endtask
  task automatic t_table;
    wr(CTRL_OFS, {27'h0, CM_PR_V});
    wr(FUNC_OFS, {24'h0, FN_POS_VEL});
    wr(POS_TABLE_OFS + 8'h14, 32'h1234_5678);
    host_u.fire(4'h5);
    settle();
    chk("pos in vel", 32'h0, drive_cmd.pos_cmd);
    host_u.drive(1'b1, 2'h0, 2'h0, 16'h0000);
    settle();
    chk("hold", 32'h1, {31'h0, drive_cmd.motion_hold});
    chk("pos before trigger", 32'h0, drive_cmd.pos_cmd);
    host_u.fire(4'h5);
    settle();
    chk("table pos", 32'h1234_5678, drive_cmd.pos_cmd);
    chk("moving", 32'h0, {31'h0, drive_cmd.motion_hold});
    host_u.drive(1'b0, 2'h0, 2'h0, 16'h0000);
    mode_is(MODE_VEL);
    $display("test table done");
  endtask
  task automatic t_pulse;
    wr(CTRL_OFS, {27'h0, CM_PT_T});
    wr(FUNC_OFS, {24'h0, FN_POS_TRQ});
    host_u.drive(1'b1, 2'h0, 2'h0, 16'h0000);
    host_u.pulses(7);
    settle();
    chk("pulse pos", 32'h0000_0007, drive_cmd.pos_cmd);
    @(posedge aclk);
    ce <= 1'b0;
    host_u.pulses(3);
    settle();
    chk("frozen pos", 32'h0000_0007, drive_cmd.pos_cmd);
    ce <= 1'b1;
    settle();
    chk("pos after enable", 32'h0000_000a, drive_cmd.pos_cmd);
    $display("test pulse done");
  endtask
  task automatic t_cmds;
    wr(CTRL_OFS, {27'h0, CM_V_T});
    wr(FUNC_OFS, {24'h0, FN_VEL_TRQ});
    wr(MAX_VEL_OFS, 32'h0000_0080);
    wr(VEL_PRESET_OFS + 8'h04, 32'h0000_0100);
    wr(TRQ_PRESET_OFS + 8'h08, 32'h0000_0033);
    host_u.drive(1'b0, 2'h2, 2'h0, 16'h0040);
    settle();
    chk("vel clamp", 32'h0000_0080, {16'h0, drive_cmd.vel_cmd});
    host_u.drive(1'b0, 2'h0, 2'h0, 16'hffc0);
    settle();
    chk("vel analog", 32'h0000_ffc0, {16'h0, drive_cmd.vel_cmd});
    host_u.drive(1'b1, 2'h0, 2'h3, 16'h0040);
    settle();
    chk("trq preset", 32'h0000_0033, {16'h0, drive_cmd.trq_cmd});
    host_u.drive(1'b1, 2'h0, 2'h0, 16'h0040);
    settle();
    chk("trq analog", 32'h0000_0040, {16'h0, drive_cmd.trq_cmd});
    wr(CTRL_OFS, {26'h0, 1'b1, CM_V_T});
    settle();
    chk("trq zero", 32'h0, {16'h0, drive_cmd.trq_cmd});
    $display("test commands done");
  endtask
  task automatic t_limits;
    wr(MAX_VEL_OFS, 32'h0000_0200);
    wr(CTRL_OFS, {20'h0, 4'h1, 3'h0, CM_V_T});
    host_u.drive(1'b1, 2'h2, 2'h1, 16'h0000);
    settle();
    chk("vlim on", 32'h1, {31'h0, drive_cmd.vel_limit_on});
    chk("vlim", 32'h0000_0100, {16'h0, drive_cmd.vel_limit});
    wr(CTRL_OFS, {16'h0, 4'h1, 7'h0, CM_V_T});
    host_u.drive(1'b0, 2'h0, 2'h3, 16'h0000);
    settle();
    chk("tlim on", 32'h1, {31'h0, drive_cmd.trq_limit_on});
    chk("tlim", 32'h0000_0033, {16'h0, drive_cmd.trq_limit});
    $display("test limits done");
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    aresetn = 1'b0;
    {ce, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, awprot, arprot, wdata, wstrb} = 58'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_pairs();
    t_table();
    t_pulse();
    t_cmds();
    t_limits();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    give_up();
  end
endmodule // dual_mode_select_tb
